// [design/sscd_pkg.sv]
package sscd_pkg;
  // ==========================================================
  // register word indices
  localparam logic [3:0] REG_TIMER = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h1;
  localparam logic [3:0] REG_STATE = 4'h2;
  localparam logic [3:0] REG_CAUSE = 4'h3;
  localparam logic [3:0] REG_QUEUE = 4'h4;
  localparam logic [3:0] REG_MADDR = 4'h5;
  localparam logic [3:0] REG_MDATA = 4'h6;
  localparam logic [3:0] REG_MCMD = 4'h7;
  localparam logic [3:0] REG_OMODE = 4'h8;
  localparam logic [3:0] REG_IRQ_STS = 4'h9;
  localparam logic [3:0] REG_IRQ_MASK = 4'hA;
  localparam logic [3:0] REG_WIDTH = 4'hB;
  // ==========================================================
  // field positions
  localparam int TMR_SSR_BIT = 7;
  localparam int CMD_RUN_BIT = 6;
  localparam int CMD_CLR_BIT = 4;
  localparam int STATE_MAP_BIT = 7;
  localparam int STATE_TAC_BIT = 6;
  localparam int CAUSE_FLAG_BIT = 6;
  localparam int OMODE_ON_BIT = 6;
  localparam int MCMD_RWS_BIT = 7;
  localparam int QUEUE_VALID_BIT = 7;
  localparam int IRQ_QUEUED_BIT = 0;
  localparam int IRQ_HELD_BIT = 1;
  // ==========================================================
  // reset values and codes
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [7:0] OMODE_RESET = 8'h80;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [3:0] MOC_DATA = 4'h9;
  localparam logic [2:0] MOC_CODE_HI = 3'h7;
  localparam logic [3:0] CODE_EVEN = 4'hA;
  localparam logic [3:0] CODE_ODD = 4'hB;
  localparam logic [1:0] WIDTH_CI4 = 2'h0;
  localparam logic [1:0] WIDTH_SIG6 = 2'h1;
  localparam logic [1:0] WIDTH_SIG8 = 2'h2;
  localparam logic [7:0] MASK_CI4 = 8'h3C;
  localparam logic [7:0] MASK_SIG6 = 8'hFC;
  localparam logic [7:0] MASK_SIG8 = 8'hFF;
  // ==========================================================
  // timing
  localparam int FRAME_US = 125;
  localparam int TIMER_UNIT_US = 250;
  localparam int FRAMES_PER_UNIT = TIMER_UNIT_US / FRAME_US;
  localparam int QUEUE_DEPTH = 9;
  typedef enum logic {SSCD_IDLE, SSCD_SCAN} sscd_scan_t;
endpackage

// [design/sscd_addr_queue.sv]
`timescale 1ns/1ps
module sscd_addr_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] din,
  // drain side
  input wire logic pop,
  input wire logic clear,
  output logic [WIDTH-1:0] dout,
  // status
  output logic empty,
  output logic full,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic do_push;
  logic do_pop;

  assign empty = (count == '0);
  assign full = (count == ($clog2(DEPTH+1))'(DEPTH));
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  // empty head reads as zero, so its valid bit is clear
  assign dout = empty ? '0 : mem[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= din;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || clear)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count <= count + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// [design/sscd_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - 4-bit indication value in odd slot is sampled every frame, kept at even address.
// - each changed 4-bit value sets the event flag and queues its even address.
// - valid queue entries carry a one in the top bit.
// - 6/8-bit values sampled per frame or per timer period, stored at even address.
// - stable value updates only on two equal samples differing from it.
// - stable value sits at the odd address of the pair.
// - each stable change sets the event flag and queues the odd address.
// - fixed rate select set: per-frame sampling, no timer needed.
// - fixed rate select clear: no 6/8-bit detection or flag until timer runs.
// - port not operational: received values ignored, memory left untouched.
// - on activation, values equal to preloaded ones raise nothing.
// - after 1010/1011 setup, even-slot data is sent in the odd slot.
// - queue holds nine; surplus changes wait and are written as room frees.
// - surplus changes leave indication and stable values untouched until the queue has room.
// - clear command empties the queue and flag within two bit clocks.
// - reading cause does not clear flag; flag clears when queue empty.
module sscd_top #(
  parameter int NUM_SLOTS = 32,
  parameter int QDEPTH = sscd_pkg::QUEUE_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // serial port
  input wire logic receive_bit_clock,
  input wire logic frame_sync,
  input wire logic up_data_in,
  output logic down_data_out
);
  localparam int SW = $clog2(NUM_SLOTS);
  localparam int NUM_PAIRS = NUM_SLOTS / 2;
  localparam int PW = $clog2(NUM_PAIRS);

  // ==========================================================
  // registers
  logic [7:0] timer_config_reg;
  logic [7:0] operating_mode_reg;
  logic [7:0] memory_address_reg;
  logic [7:0] memory_data_reg;
  logic [7:0] memory_command_reg;
  logic [1:0] width_reg;
  logic [1:0] irq_sts_reg;
  logic [1:0] irq_mask_reg;
  logic memory_access_pending;
  logic timer_active;
  logic wait_q;
  logic wr_go;
  logic rd_go;
  logic port_on;
  logic fixed_sample_rate_select;

  assign avs_waitrequest = wait_q;
  assign wr_go = avs_write && !wait_q;
  assign rd_go = avs_read && !wait_q;
  assign port_on = operating_mode_reg[sscd_pkg::OMODE_ON_BIT];
  assign fixed_sample_rate_select = timer_config_reg[sscd_pkg::TMR_SSR_BIT];

  // ==========================================================
  // queue
  logic q_push;
  logic q_pop;
  logic q_clear;
  logic q_empty;
  logic q_full;
  logic [7:0] q_din;
  logic [7:0] q_dout;
  logic [$clog2(QDEPTH+1)-1:0] q_count;

  assign q_clear = wr_go && avs_address == sscd_pkg::REG_CMD
    && avs_writedata[sscd_pkg::CMD_CLR_BIT];
  // pop only an entry that was shown valid to the master
  assign q_pop = rd_go && avs_address == sscd_pkg::REG_QUEUE
    && avs_readdata[sscd_pkg::QUEUE_VALID_BIT];

  sscd_addr_queue #(.WIDTH(8), .DEPTH(QDEPTH)) u_queue (
    .clk(clk),
    .rst(rst),
    .push(q_push),
    .din(q_din),
    .pop(q_pop),
    .clear(q_clear),
    .dout(q_dout),
    .empty(q_empty),
    .full(q_full),
    .count(q_count)
  );

  // ==========================================================
  // bus slave
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wait_q <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else if ((avs_read || avs_write) && wait_q)
    begin
      wait_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      unique case (avs_address)
        sscd_pkg::REG_TIMER: avs_readdata[7:0] <= timer_config_reg;
        sscd_pkg::REG_STATE: avs_readdata[7:0] <= {memory_access_pending, timer_active, 6'h00};
        sscd_pkg::REG_CAUSE: avs_readdata[sscd_pkg::CAUSE_FLAG_BIT] <= !q_empty;
        sscd_pkg::REG_QUEUE: avs_readdata[7:0] <= q_dout;
        sscd_pkg::REG_MADDR: avs_readdata[7:0] <= memory_address_reg;
        sscd_pkg::REG_MDATA: avs_readdata[7:0] <= memory_data_reg;
        sscd_pkg::REG_MCMD: avs_readdata[7:0] <= memory_command_reg;
        sscd_pkg::REG_OMODE: avs_readdata[7:0] <= operating_mode_reg;
        sscd_pkg::REG_IRQ_STS: avs_readdata[1:0] <= irq_sts_reg;
        sscd_pkg::REG_IRQ_MASK: avs_readdata[1:0] <= irq_mask_reg;
        sscd_pkg::REG_WIDTH: avs_readdata[1:0] <= width_reg;
        default: avs_readdata <= 32'h00000000;
      endcase
    end
    else
    begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      timer_config_reg <= sscd_pkg::TIMER_RESET;
      operating_mode_reg <= sscd_pkg::OMODE_RESET;
      memory_address_reg <= 8'h00;
      memory_command_reg <= 8'h00;
      width_reg <= sscd_pkg::WIDTH_CI4;
      irq_mask_reg <= sscd_pkg::IRQ_MASK_RESET;
    end
    else if (wr_go)
    begin
      unique case (avs_address)
        sscd_pkg::REG_TIMER: timer_config_reg <= avs_writedata[7:0];
        sscd_pkg::REG_MADDR: memory_address_reg <= avs_writedata[7:0];
        sscd_pkg::REG_MCMD: memory_command_reg <= avs_writedata[7:0];
        sscd_pkg::REG_OMODE: operating_mode_reg <= avs_writedata[7:0];
        sscd_pkg::REG_IRQ_MASK: irq_mask_reg <= avs_writedata[1:0];
        sscd_pkg::REG_WIDTH: width_reg <= avs_writedata[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // serial port sampling
  logic [2:0] rcl_s;
  logic [2:0] fs_s;
  logic [1:0] du_s;
  logic rcl_rise;
  logic frame_start;
  logic [2:0] bit_cnt;
  logic [SW-1:0] slot_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] rx_latch [NUM_PAIRS];

  assign rcl_rise = rcl_s[1] && !rcl_s[2];
  assign frame_start = fs_s[1] && !fs_s[2];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rcl_s <= 3'h0;
      fs_s <= 3'h0;
      du_s <= 2'h0;
    end
    else
    begin
      rcl_s <= {rcl_s[1:0], receive_bit_clock};
      fs_s <= {fs_s[1:0], frame_sync};
      du_s <= {du_s[0], up_data_in};
    end
  end

  // ==========================================================
  // memories
  logic [7:0] up_data [NUM_SLOTS];
  logic [3:0] up_code [NUM_SLOTS];
  logic [7:0] dn_data [NUM_SLOTS];
  logic [3:0] dn_code [NUM_SLOTS];
  logic [7:0] last_sample [NUM_PAIRS];
  logic [SW-1:0] tx_slot;

  // odd slot of a set-up pair sends the even slot's data
  always_comb
  begin
    tx_slot = slot_cnt;
    if (slot_cnt[0] && dn_code[{slot_cnt[SW-1:1], 1'b0}] == sscd_pkg::CODE_EVEN
      && dn_code[slot_cnt] == sscd_pkg::CODE_ODD)
    begin
      tx_slot = {slot_cnt[SW-1:1], 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || frame_start)
    begin
      bit_cnt <= 3'h0;
      slot_cnt <= '0;
      rx_sh <= 8'h00;
      tx_sh <= 8'hFF;
      down_data_out <= 1'b1;
    end
    else if (rcl_rise)
    begin
      rx_sh <= {rx_sh[6:0], du_s[1]};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h0)
      begin
        down_data_out <= dn_data[tx_slot][7];
        tx_sh <= {dn_data[tx_slot][6:0], 1'b1};
      end
      else
      begin
        down_data_out <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b1};
      end
      if (bit_cnt == 3'h7)
      begin
        slot_cnt <= slot_cnt + 1'b1;
      end
    end
  end

  // odd upstream slot byte lands in its pair latch
  always_ff @(posedge clk)
  begin
    if (rcl_rise && bit_cnt == 3'h7 && slot_cnt[0])
    begin
      rx_latch[slot_cnt[SW-1:1]] <= {rx_sh[6:0], du_s[1]};
    end
  end

  // ==========================================================
  // timer
  logic [7:0] frame_cnt;
  logic timer_tick;
  logic [7:0] timer_limit;

  assign timer_limit = 8'(({1'b0, timer_config_reg[6:0]} + 8'h01)
    * 8'(sscd_pkg::FRAMES_PER_UNIT) - 8'h01);
  assign timer_tick = timer_active && frame_start && frame_cnt == timer_limit;

  always_ff @(posedge clk)
  begin
    if (rst || !port_on || (wr_go && avs_address == sscd_pkg::REG_TIMER))
    begin
      timer_active <= 1'b0;
      frame_cnt <= 8'h00;
    end
    else
    begin
      if (wr_go && avs_address == sscd_pkg::REG_CMD && avs_writedata[sscd_pkg::CMD_RUN_BIT])
      begin
        timer_active <= 1'b1;
      end
      if (frame_start && timer_active)
      begin
        frame_cnt <= timer_tick ? 8'h00 : frame_cnt + 8'h01;
      end
    end
  end

  // ==========================================================
  // change detection scan
  sscd_pkg::sscd_scan_t scan_state;
  logic [PW-1:0] scan_idx;
  logic sample_now;
  logic [7:0] mask;
  logic [7:0] rx_v;
  logic [SW-1:0] ev_slot;
  logic [SW-1:0] od_slot;
  logic cs_pair;
  logic is_ci;
  logic ci_chg;
  logic prev_match;
  logic st_chg;
  logic want_push;
  logic held;
  logic mem_go;

  assign ev_slot = {scan_idx, 1'b0};
  assign od_slot = {scan_idx, 1'b1};
  assign rx_v = rx_latch[scan_idx] & mask;
  assign is_ci = width_reg == sscd_pkg::WIDTH_CI4;
  assign cs_pair = scan_state == sscd_pkg::SSCD_SCAN && port_on
    && up_code[ev_slot] == sscd_pkg::CODE_EVEN;
  assign ci_chg = rx_v != (up_data[ev_slot] & mask);
  assign prev_match = rx_v == (last_sample[scan_idx] & mask);
  assign st_chg = rx_v != (up_data[od_slot] & mask);
  assign want_push = cs_pair && (is_ci ? ci_chg : (sample_now && prev_match && st_chg));
  assign q_push = want_push && !q_full;
  assign held = want_push && q_full;
  assign q_din = {1'b1, 7'(is_ci ? ev_slot : od_slot)};
  assign mem_go = memory_access_pending && scan_state == sscd_pkg::SSCD_IDLE;

  always_comb
  begin
    unique case (width_reg)
      sscd_pkg::WIDTH_SIG6: mask = sscd_pkg::MASK_SIG6;
      sscd_pkg::WIDTH_SIG8: mask = sscd_pkg::MASK_SIG8;
      default: mask = sscd_pkg::MASK_CI4;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scan_state <= sscd_pkg::SSCD_IDLE;
      scan_idx <= '0;
      sample_now <= 1'b0;
    end
    else
    begin
      unique case (scan_state)
        sscd_pkg::SSCD_IDLE:
        begin
          if (frame_start)
          begin
            scan_state <= sscd_pkg::SSCD_SCAN;
            scan_idx <= '0;
            sample_now <= fixed_sample_rate_select || timer_tick;
          end
        end
        sscd_pkg::SSCD_SCAN:
        begin
          scan_idx <= scan_idx + 1'b1;
          if (scan_idx == PW'(NUM_PAIRS - 1))
          begin
            scan_state <= sscd_pkg::SSCD_IDLE;
          end
        end
      endcase
    end
  end

  // upstream memory: scan updates, else software access
  always_ff @(posedge clk)
  begin
    if (cs_pair)
    begin
      if (is_ci)
      begin
        if (q_push)
        begin
          up_data[ev_slot] <= rx_latch[scan_idx];
        end
      end
      else if (sample_now)
      begin
        up_data[ev_slot] <= rx_latch[scan_idx];
        last_sample[scan_idx] <= rx_latch[scan_idx];
        if (q_push)
        begin
          up_data[od_slot] <= rx_latch[scan_idx];
        end
      end
    end
    else if (mem_go && memory_address_reg[7] && !memory_command_reg[sscd_pkg::MCMD_RWS_BIT])
    begin
      if (memory_command_reg[6:4] == sscd_pkg::MOC_CODE_HI)
      begin
        up_code[memory_address_reg[SW-1:0]] <= memory_command_reg[3:0];
        up_data[memory_address_reg[SW-1:0]] <= memory_data_reg;
      end
      else if (memory_command_reg[6:3] == sscd_pkg::MOC_DATA)
      begin
        up_data[memory_address_reg[SW-1:0]] <= memory_data_reg;
      end
    end
  end

  // downstream memory: software only
  always_ff @(posedge clk)
  begin
    if (mem_go && !memory_address_reg[7] && !memory_command_reg[sscd_pkg::MCMD_RWS_BIT])
    begin
      if (memory_command_reg[6:4] == sscd_pkg::MOC_CODE_HI)
      begin
        dn_code[memory_address_reg[SW-1:0]] <= memory_command_reg[3:0];
        dn_data[memory_address_reg[SW-1:0]] <= memory_data_reg;
      end
      else if (memory_command_reg[6:3] == sscd_pkg::MOC_DATA)
      begin
        dn_data[memory_address_reg[SW-1:0]] <= memory_data_reg;
      end
    end
  end

  // memory access pending and read-back
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      memory_access_pending <= 1'b0;
      memory_data_reg <= 8'h00;
    end
    else if (wr_go && avs_address == sscd_pkg::REG_MCMD)
    begin
      memory_access_pending <= 1'b1;
    end
    else if (wr_go && avs_address == sscd_pkg::REG_MDATA)
    begin
      memory_data_reg <= avs_writedata[7:0];
    end
    else if (mem_go)
    begin
      memory_access_pending <= 1'b0;
      if (memory_command_reg[sscd_pkg::MCMD_RWS_BIT])
      begin
        memory_data_reg <= memory_address_reg[7] ? up_data[memory_address_reg[SW-1:0]]
          : dn_data[memory_address_reg[SW-1:0]];
      end
    end
  end

  // ==========================================================
  // interrupts
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_sts_reg <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_go && avs_address == sscd_pkg::REG_IRQ_STS && avs_writedata[i])
        begin
          irq_sts_reg[i] <= 1'b0;
        end
      end
      if (q_push)
      begin
        irq_sts_reg[sscd_pkg::IRQ_QUEUED_BIT] <= 1'b1;
      end
      if (held)
      begin
        irq_sts_reg[sscd_pkg::IRQ_HELD_BIT] <= 1'b1;
      end
      irq <= |(irq_sts_reg & irq_mask_reg);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_clear_cmd;
    q_clear;
  endsequence
  sequence s_empty_pop;
    rd_go && avs_address == sscd_pkg::REG_QUEUE && !avs_readdata[7];
  endsequence
  AST_VALID_MSB: assert property (q_push |-> q_din[7])
    else $error("queue entry pushed without valid bit");
  AST_CI_EVEN: assert property (q_push && is_ci |-> !q_din[0])
    else $error("indication change queued at odd address");
  AST_SIG_ODD: assert property (q_push && !is_ci |-> q_din[0] && prev_match && st_chg)
    else $error("stable change queued without double look");
  AST_FULL_HOLD: assert property (q_full |-> !q_push ##1
    (q_full || $past(q_pop) || $past(q_clear)))
    else $error("queue grew past its depth");
  AST_CLEAR: assert property (s_clear_cmd |=> q_empty && q_count == '0)
    else $error("clear command left entries");
  AST_IDLE_PORT: assert property (!port_on |-> !q_push && !held)
    else $error("change detected while port not operational");
  AST_NO_TIMER: assert property (!fixed_sample_rate_select && !timer_active |=> !(q_push && !is_ci))
    else $error("signal change without running timer");
  AST_EMPTY_READ: assert property (s_empty_pop |=> q_count == $past(q_count)
    || $past(q_push) || $past(q_clear))
    else $error("empty queue read disturbed state");
  AST_FLAG_KEEP: assert property (rd_go && avs_address == sscd_pkg::REG_CAUSE && !q_empty
    && !q_pop && !q_clear |=> !q_empty)
    else $error("cause read cleared change flag");
endmodule

// [dv/sscd_line_model.sv]
`timescale 1ns/1ps
module sscd_line_model #(
  parameter int NUM_SLOTS = 20,
  parameter logic [7:0] FILL = 8'hFF
) (
  // clock
  input wire logic clk,
  // serial port
  output logic receive_bit_clock,
  output logic frame_sync,
  output logic up_data_in,
  input wire logic down_data_out
);
  // ==========================================================
  // free-running frame, msb first, data moves on the falling bit clock
  logic [7:0] up_slot [NUM_SLOTS];
  logic [7:0] down_slot [NUM_SLOTS];
  initial
  begin
    foreach (up_slot[i]) up_slot[i] = FILL;
    receive_bit_clock = 1'b0;
    forever
      for (int s = 0; s < NUM_SLOTS; s++)
        for (int b = 7; b >= 0; b--)
        begin
          frame_sync <= (s == 0) && (b == 7);
          up_data_in <= up_slot[s][b];
          repeat (5) @(posedge clk);
          receive_bit_clock <= 1'b1;
          repeat (4) @(posedge clk);
          @(negedge clk);
          down_slot[s][b] = down_data_out;
          @(posedge clk);
          receive_bit_clock <= 1'b0;
        end
  end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // signals
  localparam logic [7:0] IDLE_V = 8'hD7;
  localparam logic [7:0] CI_A = 8'hEB;
  localparam logic [7:0] CI_B = 8'hE7;
  localparam logic [7:0] SIG_V = 8'h33;
  localparam logic [7:0] RD_CMD = {1'b1, sscd_pkg::MOC_DATA, 3'h0};
  localparam logic [7:0] UP_CMD = {1'b0, sscd_pkg::MOC_CODE_HI, sscd_pkg::CODE_EVEN};
  typedef struct packed {logic [3:0] a; logic [7:0] v;} sscd_row_t;
  sscd_row_t rows [7] = '{'{sscd_pkg::REG_OMODE, 8'h80}, '{sscd_pkg::REG_TIMER, 8'h00},
    '{sscd_pkg::REG_CAUSE, 8'h00}, '{sscd_pkg::REG_QUEUE, 8'h00},
    '{sscd_pkg::REG_IRQ_MASK, 8'h00}, '{sscd_pkg::REG_WIDTH, 8'h00}, '{4'hF, 8'h00}};
  logic clk;
  logic rst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic receive_bit_clock;
  logic frame_sync;
  logic up_data_in;
  logic down_data_out;
  logic [31:0] rd;
  int failures;
  int total_checks;
  sscd_top #(.NUM_SLOTS(20)) i_dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .receive_bit_clock,
    .frame_sync, .up_data_in, .down_data_out);
  sscd_line_model #(.NUM_SLOTS(20), .FILL(IDLE_V)) i_line (.clk, .receive_bit_clock,
    .frame_sync, .up_data_in, .down_data_out);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic finish_test();
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic mem(input logic [7:0] a, input logic [7:0] cmd, input logic [7:0] d);
    bus(sscd_pkg::REG_MADDR, 1'b1, a);
    bus(sscd_pkg::REG_MDATA, 1'b1, d);
    bus(sscd_pkg::REG_MCMD, 1'b1, cmd);
    rd = 32'hFF;
    while (rd[7] !== 1'b0) bus(sscd_pkg::REG_STATE, 1'b0, 8'h00);
    bus(sscd_pkg::REG_MDATA, 1'b0, 8'h00);
  endtask
  task automatic mchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    mem(a, RD_CMD, 8'h00);
    chk(rd & {24'h000000, m}, {24'h000000, exp & m});
  endtask
  task automatic qchk(input logic [7:0] exp);
    bus(sscd_pkg::REG_QUEUE, 1'b0, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge frame_sync);
    repeat (60) @(posedge clk);
  endtask
  task automatic set_up(input int first, input int last, input logic [7:0] v);
    @(posedge frame_sync);
    for (int s = first; s <= last; s += 2) i_line.up_slot[s] = v;
    @(posedge clk);
  endtask
  initial
  begin
    #9_500_000;
    failures++;
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i])
    begin
      bus(rows[i].a, 1'b0, 8'h00);
      chk(rd, {24'h000000, rows[i].v});
    end
    for (int s = 0; s < 20; s++) mem({3'h4, s[4:0]}, UP_CMD, IDLE_V);
    mem(8'h02, UP_CMD, 8'hC3);
    mem(8'h03, {1'b0, sscd_pkg::MOC_CODE_HI, sscd_pkg::CODE_ODD}, 8'hFF);
    set_up(1, 1, CI_A);
    frames(2);
    qchk(8'h00);
    mchk(8'h80, 8'h3C, IDLE_V);
    set_up(1, 1, IDLE_V);
    frames(1);
    bus(sscd_pkg::REG_OMODE, 1'b1, 8'hEE);
    frames(2);
    qchk(8'h00);
    bus(sscd_pkg::REG_WIDTH, 1'b1, 8'h01);
    mem(8'h02, {1'b0, sscd_pkg::MOC_DATA, 3'h0}, IDLE_V);
    frames(2);
    chk({24'h000000, i_line.down_slot[3]}, {24'h000000, IDLE_V});
    set_up(7, 7, SIG_V);
    frames(3);
    qchk(8'h00);
    bus(sscd_pkg::REG_CMD, 1'b1, 8'h40);
    frames(6);
    qchk(8'h87);
    mchk(8'h86, 8'hFC, SIG_V);
    mchk(8'h87, 8'hFC, SIG_V);
    bus(sscd_pkg::REG_TIMER, 1'b1, 8'h80);
    set_up(7, 7, IDLE_V);
    set_up(7, 7, SIG_V);
    frames(2);
    qchk(8'h00);
    set_up(7, 7, IDLE_V);
    frames(2);
    qchk(8'h87);
    bus(sscd_pkg::REG_WIDTH, 1'b1, 8'h00);
    set_up(1, 1, CI_A);
    frames(1);
    bus(sscd_pkg::REG_CAUSE, 1'b0, 8'h00);
    chk(rd & 32'h40, 32'h40);
    bus(sscd_pkg::REG_CAUSE, 1'b0, 8'h00);
    chk(rd & 32'h40, 32'h40);
    chk({31'h0, irq}, 32'h0);
    bus(sscd_pkg::REG_IRQ_MASK, 1'b1, 8'h01);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    qchk(8'h80);
    mchk(8'h80, 8'h3C, CI_A);
    qchk(8'h00);
    bus(sscd_pkg::REG_CAUSE, 1'b0, 8'h00);
    chk(rd & 32'h40, 32'h0);
    bus(sscd_pkg::REG_IRQ_STS, 1'b1, 8'h01);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    set_up(1, 19, CI_B);
    frames(1);
    bus(sscd_pkg::REG_IRQ_STS, 1'b0, 8'h00);
    chk(rd & 32'h2, 32'h2);
    mchk(8'h92, 8'h3C, IDLE_V);
    for (int i = 0; i < 9; i++) qchk(8'h80 + 8'(2 * i));
    qchk(8'h00);
    frames(1);
    qchk(8'h92);
    mchk(8'h92, 8'h3C, CI_B);
    set_up(1, 19, IDLE_V);
    frames(1);
    bus(sscd_pkg::REG_CMD, 1'b1, 8'h10);
    bus(sscd_pkg::REG_CAUSE, 1'b0, 8'h00);
    chk(rd & 32'h40, 32'h0);
    qchk(8'h00);
    finish_test();
  end
endmodule
